// [rtl/ipcp_params.svh]
// Constants shared by both ends of the interpolated and cyclic position link
`ifndef IPCP_PARAMS_SVH
`define IPCP_PARAMS_SVH

`define IPCP_CLK_NS      10
`define IPCP_MS_NS       1000000
`define IPCP_MS_CYC      (`IPCP_MS_NS / `IPCP_CLK_NS)

`define IPCP_MODE_IP     8'h07
`define IPCP_MODE_CSP    8'h08
`define IPCP_TIDX_MS     8'hFD
`define IPCP_BUFCFG_ON   32'h0000_0001
`define IPCP_HALTOPT_PRF 16'h0001

`define IPCP_CW_IPEN     4
`define IPCP_CW_HALT     8
`define IPCP_SW_SYNC     8
`define IPCP_SW_REACHED  10
`define IPCP_SW_LIMIT    11
`define IPCP_SW_ACTIVE   12
`define IPCP_SW_FERR     13

`define IPCP_RST_PERIOD  16'h0001
`define IPCP_RST_TIDX    8'hFD
`define IPCP_RST_LIMLO   32'h8000_0000
`define IPCP_RST_LIMHI   32'h7FFF_FFFF
`define IPCP_RST_SPEED   32'h7FFF_FFFF

`define IPCP_ADDR_SEL    8'h00
`define IPCP_ADDR_DATA   8'h04
`define IPCP_ADDR_SYNC   8'h08
`define IPCP_ADDR_STAT   8'h0C
`define IPCP_ADDR_STAGE  8'h10
`define IPCP_ADDR_PEND   8'h14

`define IPCP_DIV_STEPS   6'h20
`endif

// [rtl/ipcp_pkg.sv]
// Types shared by both ends of the position link
package ipcp_pkg;
  typedef enum logic [4:0] {
    OBJ_MODE, OBJ_CTRL, OBJ_IP_TARGET, OBJ_PERIOD, OBJ_TIME_IDX, OBJ_BUF_CFG,
    OBJ_CSP_TARGET, OBJ_POS_OFS, OBJ_VEL_OFS, OBJ_TRQ_OFS, OBJ_FE_WIN, OBJ_FE_TMO,
    OBJ_LIM_LO, OBJ_LIM_HI, OBJ_MAX_PROF_VEL, OBJ_MAX_MOT_SPD, OBJ_START_ACC,
    OBJ_PROF_DEC, OBJ_MAX_DEC, OBJ_HALT_OPT
  } ipcp_obj_t;

  typedef enum logic [1:0] {DIV_IDLE, DIV_RUN, DIV_APPLY} ipcp_div_t;
endpackage

// [rtl/ipcp_link_if.sv]
// Link between the motion controller and the drive
`timescale 1ns/100ps
interface ipcp_link_if (
  input wire logic clk,
  input wire logic rstn
);
  logic                objWr;
  ipcp_pkg::ipcp_obj_t objSel;
  logic [31:0]         objData;
  logic                syncPulse;
  logic [15:0]         statusWord;

  modport host (output objWr, output objSel, output objData, output syncPulse, input statusWord);
  modport dev  (input objWr, input objSel, input objData, input syncPulse, output statusWord);
endinterface

// [rtl/ipcp_drive.sv]
// Drive end: interpolated and cyclic synchronous position set-point logic
// How it works
// R01 - Controller writes mode 7 for interpolation
// R02 - Interpolation runs only while control bit 4 set
// R03 - Halt set stops; release ramps up with start ramp
// R04 - Halt rising edge brakes per halt option code
// R05 - Bit 10: target reached, or standstill under halt
// R06 - Bit 12 shows interpolation active
// R07 - Bit 13 following error in closed loop
// R08 - Linear path from present position to target
// R09 - Target spacing comes from period in ms
// R10 - Target writes need buffer config set to 1
// R11 - Closed loop limits speed to smaller maximum
// R12 - Controller delivers each target in time
// R13 - Cyclic mode tracks each absolute target, no ramps
// R14 - Repeated identical target changes nothing
// R15 - Cyclic mode ignores control bit 4
// R16 - Controller writes mode 8 for cyclic mode
// R17 - Controller sends sync at regular intervals
// R18 - Bit 8 shows sync with fieldbus
// R19 - Bit 12 shows cyclic target in use
// R20 - Bit 11 demand outside software limits
// R21 - Following error after corridor timeout in ms
// R22 - Cycle time is period times ten to index; code runs only with the ms index FD, others stop the cycle clock
// R23 - Cyclic mode adds position, velocity, torque offsets
// R24 - Re-entering corridor restarts timeout count
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "ipcp_params.svh"
module ipcp_drive #(
  parameter int MS_CYCLES = `IPCP_MS_CYC
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  ipcp_link_if.dev          link,
  input  wire logic         operational,
  input  wire logic         closedLoop,
  input  wire logic [31:0]  actualPos,
  output logic [31:0]       demandPos,
  output logic [31:0]       velSet,
  output logic [15:0]       trqSet,
  output logic              interpolationRunning
);
  logic [7:0]  mode_r, timeIdx_r;
  logic [15:0] ctrl_r, periodMs_r, trqOfs_r, feTmo_r, haltOpt_r;
  logic [31:0] ipTarget_r, bufCfg_r, cspTarget_r, posOfs_r, velOfs_r, feWin_r;
  logic [31:0] limLo_r, limHi_r, maxProfVel_r, maxMotSpd_r, startAcc_r, profDec_r, maxDec_r;
  logic [31:0] msCnt_r, vel_r, quo_r, demand_r, velOut_r;
  logic [32:0] rem_r, remShift;
  logic [15:0] periodCnt_r, divisor_r, msSinceSync_r, feCnt_r, trqOut_r, status_r;
  logic [5:0]  divStep_r;
  logic        msTick_r, cycleTick_r, haltPrev_r, rampUp_r, negDir_r, synced_r, ferr_r, running_r;
  ipcp_pkg::ipcp_div_t divState_r;

  function automatic logic [31:0] absVal(input logic [31:0] v);
    absVal = v[31] ? 32'(-v) : v;
  endfunction

  function automatic logic [31:0] clampMag(input logic [31:0] v, input logic [31:0] lim);
    clampMag = (absVal(v) > lim) ? (v[31] ? 32'(-lim) : lim) : v;
  endfunction

  function automatic logic [31:0] rampTo(input logic [31:0] cur, input logic [31:0] tgt,
                                          input logic [31:0] step);
    logic [31:0] d;
    d = 32'(tgt - cur);
    rampTo = 32'(cur + clampMag(d, step));
  endfunction

  wire modeIp   = (mode_r == `IPCP_MODE_IP);
  wire modeCsp  = (mode_r == `IPCP_MODE_CSP);
  wire halt     = ctrl_r[`IPCP_CW_HALT];
  wire tidxOk   = (timeIdx_r == `IPCP_TIDX_MS);
  wire ipActive = modeIp && ctrl_r[`IPCP_CW_IPEN] && tidxOk;
  wire [31:0] speedLim = (maxProfVel_r < maxMotSpd_r) ? maxProfVel_r : maxMotSpd_r;
  wire [31:0] haltDec  = (haltOpt_r == `IPCP_HALTOPT_PRF) ? profDec_r : maxDec_r;
  wire [31:0] rawVel   = negDir_r ? 32'(-quo_r) : quo_r;
  wire [31:0] cmdVel   = halt ? 32'h0000_0000 : (closedLoop ? clampMag(rawVel, speedLim) : rawVel);
  wire [31:0] posErr   = 32'(actualPos - demand_r);
  wire        outside  = absVal(posErr) > feWin_r;
  wire        cspFollow = modeCsp && operational;

  // Object dictionary writes from the controller
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_r <= 8'h00;  ctrl_r <= 16'h0000;  ipTarget_r <= 32'h0000_0000;
      periodMs_r <= `IPCP_RST_PERIOD;  timeIdx_r <= `IPCP_RST_TIDX;  bufCfg_r <= 32'h0000_0000;
      cspTarget_r <= 32'h0000_0000;  posOfs_r <= 32'h0000_0000;  velOfs_r <= 32'h0000_0000;
      trqOfs_r <= 16'h0000;  feWin_r <= 32'h0000_0000;  feTmo_r <= 16'h0000;
      limLo_r <= `IPCP_RST_LIMLO;  limHi_r <= `IPCP_RST_LIMHI;
      maxProfVel_r <= `IPCP_RST_SPEED;  maxMotSpd_r <= `IPCP_RST_SPEED;
      startAcc_r <= 32'h0000_0000;  profDec_r <= 32'h0000_0000;  maxDec_r <= 32'h0000_0000;
      haltOpt_r <= 16'h0000;
    end else if (link.objWr) begin
      case (link.objSel)
        ipcp_pkg::OBJ_MODE:         mode_r <= link.objData[7:0];
        ipcp_pkg::OBJ_CTRL:         ctrl_r <= link.objData[15:0];
        ipcp_pkg::OBJ_IP_TARGET: begin
          if (bufCfg_r == `IPCP_BUFCFG_ON) ipTarget_r <= link.objData; // R10
        end
        ipcp_pkg::OBJ_PERIOD: begin
          if (link.objData[15:0] != 16'h0000) periodMs_r <= link.objData[15:0]; // R09
        end
        ipcp_pkg::OBJ_TIME_IDX:     timeIdx_r <= link.objData[7:0];
        ipcp_pkg::OBJ_BUF_CFG:      bufCfg_r <= link.objData;
        ipcp_pkg::OBJ_CSP_TARGET:   cspTarget_r <= link.objData; // R14
        ipcp_pkg::OBJ_POS_OFS:      posOfs_r <= link.objData;
        ipcp_pkg::OBJ_VEL_OFS:      velOfs_r <= link.objData;
        ipcp_pkg::OBJ_TRQ_OFS:      trqOfs_r <= link.objData[15:0];
        ipcp_pkg::OBJ_FE_WIN:       feWin_r <= link.objData;
        ipcp_pkg::OBJ_FE_TMO:       feTmo_r <= link.objData[15:0];
        ipcp_pkg::OBJ_LIM_LO:       limLo_r <= link.objData;
        ipcp_pkg::OBJ_LIM_HI:       limHi_r <= link.objData;
        ipcp_pkg::OBJ_MAX_PROF_VEL: maxProfVel_r <= link.objData;
        ipcp_pkg::OBJ_MAX_MOT_SPD:  maxMotSpd_r <= link.objData;
        ipcp_pkg::OBJ_START_ACC:    startAcc_r <= link.objData;
        ipcp_pkg::OBJ_PROF_DEC:     profDec_r <= link.objData;
        ipcp_pkg::OBJ_MAX_DEC:      maxDec_r <= link.objData;
        ipcp_pkg::OBJ_HALT_OPT:     haltOpt_r <= link.objData[15:0];
        default: ;
      endcase
    end
  end

  // Millisecond base; any time index other than milliseconds stops the cycle clock
  always_ff @(posedge clk) begin
    if (!rstn) begin
      msCnt_r <= 32'h0000_0000;
      msTick_r <= 1'b0;
    end else if (msCnt_r == 32'(MS_CYCLES - 1)) begin
      msCnt_r <= 32'h0000_0000;
      msTick_r <= tidxOk; // R22
    end else begin
      msCnt_r <= 32'(msCnt_r + 32'h0000_0001);
      msTick_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      periodCnt_r <= 16'h0000;
      cycleTick_r <= 1'b0;
    end else if (msTick_r) begin
      cycleTick_r <= (periodCnt_r >= 16'(periodMs_r - 16'h0001)); // R09
      periodCnt_r <= (periodCnt_r >= 16'(periodMs_r - 16'h0001)) ? 16'h0000 : 16'(periodCnt_r + 16'h0001);
    end else begin
      cycleTick_r <= 1'b0;
    end
  end

  // Velocity for the rest of the period: distance over milliseconds left.
  // Serial division takes 34 clocks, far inside one millisecond.
  assign remShift = {rem_r[31:0], quo_r[31]};
  always_ff @(posedge clk) begin
    if (!rstn) begin
      divState_r <= ipcp_pkg::DIV_IDLE;
      rem_r <= 33'h0_0000_0000;  quo_r <= 32'h0000_0000;
      divisor_r <= 16'h0001;  divStep_r <= 6'h00;  negDir_r <= 1'b0;
    end else begin
      case (divState_r)
        ipcp_pkg::DIV_IDLE: begin
          if (msTick_r && ipActive) begin
            rem_r <= 33'h0_0000_0000;
            quo_r <= absVal(32'(ipTarget_r - demand_r)); // R08
            negDir_r <= ipTarget_r[31] ^ demand_r[31] ? ipTarget_r[31] : (ipTarget_r < demand_r);
            divisor_r <= 16'(periodMs_r - periodCnt_r);
            divStep_r <= 6'h00;
            divState_r <= ipcp_pkg::DIV_RUN;
          end
        end
        ipcp_pkg::DIV_RUN: begin
          if (remShift >= {17'h0_0000, divisor_r}) begin
            rem_r <= 33'(remShift - {17'h0_0000, divisor_r});
            quo_r <= {quo_r[30:0], 1'b1};
          end else begin
            rem_r <= remShift;
            quo_r <= {quo_r[30:0], 1'b0};
          end
          divStep_r <= 6'(divStep_r + 6'h01);
          if (divStep_r == 6'(`IPCP_DIV_STEPS - 6'h01)) divState_r <= ipcp_pkg::DIV_APPLY;
        end
        default: divState_r <= ipcp_pkg::DIV_IDLE;
      endcase
    end
  end

  // Halt edges and ramp-up after release
  always_ff @(posedge clk) begin
    if (!rstn) begin
      haltPrev_r <= 1'b0;
      rampUp_r <= 1'b0;
    end else begin
      haltPrev_r <= halt;
      if (haltPrev_r && !halt) rampUp_r <= 1'b1; // R03
      else if (halt || (divState_r == ipcp_pkg::DIV_APPLY && vel_r == cmdVel)) rampUp_r <= 1'b0;
    end
  end

  // Demand position, velocity and torque set values
  always_ff @(posedge clk) begin
    if (!rstn) begin
      demand_r <= 32'h0000_0000;  vel_r <= 32'h0000_0000;
      velOut_r <= 32'h0000_0000;  trqOut_r <= 16'h0000;
    end else if (modeCsp) begin
      vel_r <= 32'h0000_0000;
      if (cycleTick_r && cspFollow) demand_r <= 32'(cspTarget_r + posOfs_r); // R13 R15 R23
      velOut_r <= velOfs_r; // R23
      trqOut_r <= trqOfs_r; // R23
    end else if (modeIp && divState_r == ipcp_pkg::DIV_APPLY) begin
      if (halt) begin
        vel_r <= rampTo(vel_r, 32'h0000_0000, haltDec); // R03 R04
        demand_r <= 32'(demand_r + rampTo(vel_r, 32'h0000_0000, haltDec));
      end else if (rampUp_r) begin
        vel_r <= rampTo(vel_r, cmdVel, startAcc_r); // R03
        demand_r <= 32'(demand_r + rampTo(vel_r, cmdVel, startAcc_r));
      end else begin
        vel_r <= cmdVel; // R08 R11
        demand_r <= 32'(demand_r + cmdVel);
      end
      velOut_r <= vel_r;
      trqOut_r <= 16'h0000;
    end else if (!ipActive) begin
      vel_r <= 32'h0000_0000; // R02
      velOut_r <= 32'h0000_0000;
      trqOut_r <= 16'h0000;
    end
  end

  // Sync supervision: lost when no pulse for two cycle periods
  always_ff @(posedge clk) begin
    if (!rstn) begin
      msSinceSync_r <= 16'hFFFF;
      synced_r <= 1'b0;
    end else begin
      if (link.syncPulse) msSinceSync_r <= 16'h0000;
      else if (msTick_r && msSinceSync_r != 16'hFFFF) msSinceSync_r <= 16'(msSinceSync_r + 16'h0001);
      synced_r <= operational && ({1'b0, msSinceSync_r} <= {periodMs_r, 1'b0}); // R18
    end
  end

  // Following error; counter restarts on return to the corridor
  always_ff @(posedge clk) begin
    if (!rstn) begin
      feCnt_r <= 16'h0000;
      ferr_r <= 1'b0;
    end else begin
      if (!outside) feCnt_r <= 16'h0000; // R24
      else if (msTick_r && feCnt_r != 16'hFFFF) feCnt_r <= 16'(feCnt_r + 16'h0001);
      ferr_r <= closedLoop && outside && (feCnt_r > feTmo_r); // R07 R21
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      status_r <= 16'h0000;
      running_r <= 1'b0;
    end else begin
      status_r <= 16'h0000;
      status_r[`IPCP_SW_LIMIT] <= ($signed(demand_r) < $signed(limLo_r)) ||
                                  ($signed(demand_r) > $signed(limHi_r)); // R20
      status_r[`IPCP_SW_FERR] <= ferr_r; // R07 R21
      if (modeIp) begin
        status_r[`IPCP_SW_REACHED] <= halt ? (vel_r == 32'h0000_0000) : (demand_r == ipTarget_r); // R05
        status_r[`IPCP_SW_ACTIVE] <= ipActive; // R06
      end else if (modeCsp) begin
        status_r[`IPCP_SW_SYNC] <= synced_r; // R18
        status_r[`IPCP_SW_ACTIVE] <= cspFollow; // R19
      end
      running_r <= ipActive; // R06
    end
  end

  assign link.statusWord      = status_r;
  assign demandPos            = demand_r;
  assign velSet               = velOut_r;
  assign trqSet               = trqOut_r;
  assign interpolationRunning = running_r;
endmodule

// [rtl/ipcp_master.sv]
// Controller end: issues object writes and sync pulses to the drive
`timescale 1ns/100ps
`include "ipcp_params.svh"
module ipcp_master #(
  parameter int MS_CYCLES = `IPCP_MS_CYC
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  ipcp_link_if.host         link,
  input  wire logic [7:0]   addr,
  input  wire logic [31:0]  wrData,
  input  wire logic         wrStb,
  input  wire logic         rdStb,
  output logic [31:0]       rdData
);
  ipcp_pkg::ipcp_obj_t sel_r, stageSel_r, objSel_r;
  logic [31:0] pendData_r, stageData_r, objData_r, rdData_r, msCnt_r;
  logic [15:0] syncPer_r, syncCnt_r;
  logic        pend_r, stagePend_r, objWr_r, sync_r, msTick_r;

  wire wrSel   = wrStb && addr == `IPCP_ADDR_SEL;
  wire wrData1 = wrStb && addr == `IPCP_ADDR_DATA;
  wire wrStage = wrStb && addr == `IPCP_ADDR_STAGE;
  wire syncDue = msTick_r && syncPer_r != 16'h0000 && syncCnt_r >= 16'(syncPer_r - 16'h0001);
  wire sendStage = syncDue && stagePend_r;
  wire sendPend  = pend_r && !sendStage;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      msCnt_r <= 32'h0000_0000;
      msTick_r <= 1'b0;
    end else begin
      msTick_r <= (msCnt_r == 32'(MS_CYCLES - 1));
      msCnt_r <= (msCnt_r == 32'(MS_CYCLES - 1)) ? 32'h0000_0000 : 32'(msCnt_r + 32'h0000_0001);
    end
  end

  // Regular sync pulses at the programmed interval
  always_ff @(posedge clk) begin
    if (!rstn) begin
      syncCnt_r <= 16'h0000;
      sync_r <= 1'b0;
    end else begin
      sync_r <= syncDue; // R17
      if (syncDue) syncCnt_r <= 16'h0000;
      else if (msTick_r) syncCnt_r <= 16'(syncCnt_r + 16'h0001);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sel_r <= ipcp_pkg::OBJ_MODE;  syncPer_r <= 16'h0000;
      pendData_r <= 32'h0000_0000;  pend_r <= 1'b0;
      stageSel_r <= ipcp_pkg::OBJ_MODE;  stageData_r <= 32'h0000_0000;  stagePend_r <= 1'b0;
    end else begin
      if (wrSel) sel_r <= ipcp_pkg::ipcp_obj_t'(wrData[4:0]);
      if (wrStb && addr == `IPCP_ADDR_SYNC) syncPer_r <= wrData[15:0];
      // A new write in the cycle its predecessor leaves keeps the pending flag set
      if (wrData1) begin
        pendData_r <= wrData;
        pend_r <= 1'b1;
      end else if (sendPend) begin
        pend_r <= 1'b0;
      end
      // Staged targets leave with the sync pulse so each period gets one in time
      if (wrStage) begin
        stageSel_r <= sel_r;
        stageData_r <= wrData;
        stagePend_r <= 1'b1; // R12
      end else if (sendStage) begin
        stagePend_r <= 1'b0;
      end
    end
  end

  // Mode selection (7 or 8) travels as an ordinary object write
  always_ff @(posedge clk) begin
    if (!rstn) begin
      objWr_r <= 1'b0;
      objSel_r <= ipcp_pkg::OBJ_MODE;
      objData_r <= 32'h0000_0000;
    end else if (sendStage) begin
      objWr_r <= 1'b1; // R12
      objSel_r <= stageSel_r;
      objData_r <= stageData_r;
    end else if (sendPend) begin
      objWr_r <= 1'b1; // R01 R16
      objSel_r <= sel_r;
      objData_r <= pendData_r;
    end else begin
      objWr_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) rdData_r <= 32'h0000_0000;
    else if (rdStb) begin
      case (addr)
        `IPCP_ADDR_SEL:   rdData_r <= {27'h000_0000, sel_r};
        `IPCP_ADDR_SYNC:  rdData_r <= {16'h0000, syncPer_r};
        `IPCP_ADDR_STAT:  rdData_r <= {16'h0000, link.statusWord};
        `IPCP_ADDR_PEND:  rdData_r <= {30'h0000_0000, stagePend_r, pend_r};
        default:          rdData_r <= 32'h0000_0000;
      endcase
    end else rdData_r <= 32'h0000_0000;
  end

  assign link.objWr     = objWr_r;
  assign link.objSel    = objSel_r;
  assign link.objData   = objData_r;
  assign link.syncPulse = sync_r;
  assign rdData         = rdData_r;
endmodule

// [test/ipcp_link_chk.sv]
// Assertion checker watching the link between controller and drive
`timescale 1ns/100ps
`include "ipcp_params.svh"
module ipcp_link_chk #(
  parameter int MS_CYCLES = `IPCP_MS_CYC
) (
  input wire logic                clk,
  input wire logic                rstn,
  input wire logic                objWr,
  input wire ipcp_pkg::ipcp_obj_t objSel,
  input wire logic [31:0]         objData,
  input wire logic                syncPulse,
  input wire logic [15:0]         statusWord
);
  logic [31:0] mode_r;
  logic [31:0] ctrl_r;
  logic [31:0] tidx_r;
  logic [31:0] period_r;
  logic [31:0] since_r;
  logic [1:0]  quiet_r;
  logic        ipMode;

  default clocking @(posedge clk); endclocking

  assign ipMode = mode_r[7:0] == `IPCP_MODE_IP;

  // Shadow copy of the objects that decide the status bits
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_r   <= 32'h0000_0000;
      ctrl_r   <= 32'h0000_0000;
      tidx_r   <= 32'h0000_00FD;
      period_r <= 32'h0000_0001;
    end else if (objWr) begin
      case (objSel)
        ipcp_pkg::OBJ_MODE:     mode_r <= objData;
        ipcp_pkg::OBJ_CTRL:     ctrl_r <= objData;
        ipcp_pkg::OBJ_TIME_IDX: tidx_r <= objData;
        ipcp_pkg::OBJ_PERIOD:   if (objData != 32'h0000_0000) period_r <= objData;
        default: ;
      endcase
    end
  end

  // Status lags a write by two cycles, so only judge it once the link is quiet
  always_ff @(posedge clk) begin
    if (!rstn) begin
      quiet_r <= 2'h0;
      since_r <= 32'(MS_CYCLES);
    end else begin
      quiet_r <= objWr ? 2'h0 : (quiet_r == 2'h3 ? quiet_r : quiet_r + 2'h1);
      since_r <= syncPulse ? 32'h0000_0000 : (&since_r ? since_r : since_r + 32'h0000_0001);
    end
  end

  reset_clear_a: assert property (!rstn |=> statusWord == 16'h0000 && !objWr && !syncPulse)
    else $error("link not idle after reset");
  first_edge_a: assert property (disable iff (!rstn) $rose(rstn) |-> !objWr ##1 !objWr)
    else $error("object sent too early after reset");
  spare_bits_a: assert property (disable iff (!rstn) (statusWord & 16'hC2FF) == 16'h0000)
    else $error("unused status bit set");
  ip_active_a: assert property (disable iff (!rstn)
    quiet_r == 2'h3 && ipMode |-> statusWord[12] == (ctrl_r[4] && tidx_r[7:0] == `IPCP_TIDX_MS))
    else $error("interpolation active bit wrong");
  idle_active_a: assert property (disable iff (!rstn)
    quiet_r == 2'h3 && !ipMode && mode_r[7:0] != `IPCP_MODE_CSP |-> !statusWord[12])
    else $error("active bit set outside both modes");
  sync_spacing_a: assert property (disable iff (!rstn) syncPulse |-> since_r >= MS_CYCLES - 1)
    else $error("sync pulses closer than one ms");
  sync_single_a: assert property (disable iff (!rstn) syncPulse |=> !syncPulse [*3])
    else $error("sync pulse longer than one cycle");
  sync_lost_a: assert property (disable iff (!rstn)
    statusWord[8] |-> since_r <= (2 * period_r + 2) * MS_CYCLES)
    else $error("sync bit held without sync pulses");

  cover property (disable iff (!rstn) syncPulse && statusWord[8]);
  cover property (disable iff (!rstn) ipMode && statusWord[12]);
  cover property (disable iff (!rstn) $rose(statusWord[13]));
  cover property (disable iff (!rstn) statusWord[11]);
endmodule

// [test/tb_top.sv]
// Self-checking bench for the controller and drive joined by the link
`timescale 1ns/100ps
`include "ipcp_params.svh"
module tb_top;
  localparam int MS = 50;
  logic        clk = 1'b0;
  logic        rstn;
  logic [7:0]  addr;
  logic [31:0] wrData;
  logic        wrStb;
  logic        rdStb;
  logic [31:0] rdData;
  logic        operational;
  logic        closedLoop;
  logic [31:0] actualPos;
  logic [31:0] demandPos;
  logic [31:0] velSet;
  logic [15:0] trqSet;
  logic        interpolationRunning;
  logic [31:0] s;
  logic [31:0] snap;
  int          errCount = 0;
  int          nCompared = 0;
  int          cyc = 0;

  always #5 clk = ~clk;

  ipcp_link_if link (.clk(clk), .rstn(rstn));
  ipcp_master #(.MS_CYCLES(MS)) ipcp_master_inst (.clk(clk), .rstn(rstn), .link(link), .addr(addr),
    .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData));
  ipcp_drive #(.MS_CYCLES(MS)) ipcp_drive_inst (.clk(clk), .rstn(rstn), .link(link),
    .operational(operational), .closedLoop(closedLoop), .actualPos(actualPos), .demandPos(demandPos),
    .velSet(velSet), .trqSet(trqSet), .interpolationRunning(interpolationRunning));
  ipcp_link_chk #(.MS_CYCLES(MS)) ipcp_link_chk_inst (.clk(clk), .rstn(rstn), .objWr(link.objWr),
    .objSel(link.objSel), .objData(link.objData), .syncPulse(link.syncPulse), .statusWord(link.statusWord));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errCount++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 s = rdData;
  endtask

  // Gap after each send lets the two-cycle status lag settle
  task automatic obj(input ipcp_pkg::ipcp_obj_t o, input logic [31:0] d);
    wr(`IPCP_ADDR_SEL, 32'(o));
    wr(`IPCP_ADDR_DATA, d);
    repeat (4) @(posedge clk);
  endtask

  task automatic sb(input int b, input logic v);
    rd(`IPCP_ADDR_STAT);
    chk({31'h0, s[b]}, {31'h0, v});
  endtask

  task automatic ms(input int n);
    repeat (n * MS) @(posedge clk);
  endtask

  task automatic finalReport;
    $display("Compared %0d, mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errCount++;
      finalReport();
    end
  end

  initial begin
    rstn = 1'b0;
    addr = 8'h00;
    wrData = 32'h0000_0000;
    wrStb = 1'b0;
    rdStb = 1'b0;
    operational = 1'b0;
    closedLoop = 1'b0;
    actualPos = 32'h0000_0000;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rd(`IPCP_ADDR_STAT);
    chk(s, 32'h0000_0000);
    chk(demandPos, 32'h0000_0000);
    $display("test reset done");

    obj(ipcp_pkg::OBJ_MODE, 32'h0000_0008);
    obj(ipcp_pkg::OBJ_POS_OFS, 32'h0000_0005);
    obj(ipcp_pkg::OBJ_VEL_OFS, 32'h0000_0007);
    obj(ipcp_pkg::OBJ_TRQ_OFS, 32'h0000_0003);
    operational <= 1'b1;
    wr(`IPCP_ADDR_SEL, 32'(ipcp_pkg::OBJ_CSP_TARGET));
    wr(`IPCP_ADDR_STAGE, 32'h0000_0064);
    wr(`IPCP_ADDR_SYNC, 32'h0000_0001);
    ms(3);
    chk(demandPos, 32'h0000_0069);
    chk(velSet, 32'h0000_0007);
    chk({16'h0, trqSet}, 32'h0000_0003);
    sb(8, 1'b1);
    sb(12, 1'b1);
    obj(ipcp_pkg::OBJ_CSP_TARGET, 32'h0000_0064);
    obj(ipcp_pkg::OBJ_CSP_TARGET, 32'h0000_0064);
    ms(2);
    chk(demandPos, 32'h0000_0069);
    wr(`IPCP_ADDR_STAGE, 32'h0000_00C8);
    ms(2);
    chk(demandPos, 32'h0000_00CD);
    $display("test cyclic done");

    obj(ipcp_pkg::OBJ_LIM_HI, 32'h0000_0096);
    sb(11, 1'b1);
    obj(ipcp_pkg::OBJ_LIM_HI, 32'h7FFF_FFFF);
    sb(11, 1'b0);
    obj(ipcp_pkg::OBJ_LIM_LO, 32'h0000_012C);
    sb(11, 1'b1);
    obj(ipcp_pkg::OBJ_LIM_LO, 32'h8000_0000);
    $display("test limit done");

    obj(ipcp_pkg::OBJ_FE_WIN, 32'h0000_000A);
    obj(ipcp_pkg::OBJ_FE_TMO, 32'h0000_0003);
    // Start inside the corridor so the timeout counts from a known point
    actualPos <= 32'h0000_00CD;
    closedLoop <= 1'b1;
    ms(2);
    sb(13, 1'b0);
    actualPos <= 32'h0000_0000;
    ms(2);
    actualPos <= 32'h0000_00CD;
    ms(1);
    actualPos <= 32'h0000_0000;
    ms(2);
    sb(13, 1'b0);
    ms(3);
    sb(13, 1'b1);
    actualPos <= 32'h0000_00C8;
    ms(1);
    sb(13, 1'b0);
    closedLoop <= 1'b0;
    actualPos <= 32'h0000_0000;
    ms(5);
    sb(13, 1'b0);
    $display("test following error done");

    wr(`IPCP_ADDR_SYNC, 32'h0000_0000);
    ms(4);
    sb(8, 1'b0);
    operational <= 1'b0;
    ms(1);
    sb(12, 1'b0);
    $display("test sync loss done");

    obj(ipcp_pkg::OBJ_MODE, 32'h0000_0007);
    obj(ipcp_pkg::OBJ_PERIOD, 32'h0000_0004);
    obj(ipcp_pkg::OBJ_MAX_DEC, 32'h7FFF_FFFF);
    obj(ipcp_pkg::OBJ_START_ACC, 32'h7FFF_FFFF);
    obj(ipcp_pkg::OBJ_BUF_CFG, 32'h0000_0001);
    obj(ipcp_pkg::OBJ_IP_TARGET, 32'h0000_03E8);
    obj(ipcp_pkg::OBJ_CTRL, 32'h0000_0010);
    ms(6);
    chk(demandPos, 32'h0000_03E8);
    chk({31'h0, interpolationRunning}, 32'h0000_0001);
    sb(12, 1'b1);
    sb(10, 1'b1);
    obj(ipcp_pkg::OBJ_BUF_CFG, 32'h0000_0000);
    obj(ipcp_pkg::OBJ_IP_TARGET, 32'h0000_0032);
    ms(6);
    chk(demandPos, 32'h0000_03E8);
    obj(ipcp_pkg::OBJ_BUF_CFG, 32'h0000_0001);
    obj(ipcp_pkg::OBJ_IP_TARGET, 32'h0000_0578);
    ms(2);
    chk({31'h0, demandPos > 32'h0000_03E8 && demandPos < 32'h0000_0578}, 32'h0000_0001);
    ms(4);
    chk(demandPos, 32'h0000_0578);
    $display("test interpolation done");

    obj(ipcp_pkg::OBJ_IP_TARGET, 32'h0000_0BB8);
    obj(ipcp_pkg::OBJ_CTRL, 32'h0000_0110);
    ms(2);
    sb(10, 1'b1);
    snap = demandPos;
    ms(2);
    chk(demandPos, snap);
    obj(ipcp_pkg::OBJ_CTRL, 32'h0000_0010);
    ms(12);
    chk(demandPos, 32'h0000_0BB8);
    // Tiny max decel means only the profile decel can stop the axis in time
    obj(ipcp_pkg::OBJ_HALT_OPT, 32'h0000_0001);
    obj(ipcp_pkg::OBJ_PROF_DEC, 32'h7FFF_FFFF);
    obj(ipcp_pkg::OBJ_MAX_DEC, 32'h0000_0001);
    obj(ipcp_pkg::OBJ_IP_TARGET, 32'h0000_0FA0);
    // Halt only once the axis is moving, so the chosen deceleration matters
    ms(1);
    obj(ipcp_pkg::OBJ_CTRL, 32'h0000_0110);
    ms(2);
    sb(10, 1'b1);
    obj(ipcp_pkg::OBJ_CTRL, 32'h0000_0010);
    ms(12);
    chk(demandPos, 32'h0000_0FA0);
    $display("test halt done");

    closedLoop <= 1'b1;
    actualPos <= 32'h0000_0FA0;
    obj(ipcp_pkg::OBJ_MAX_PROF_VEL, 32'h0000_000A);
    snap = demandPos;
    obj(ipcp_pkg::OBJ_IP_TARGET, 32'h0000_1388);
    ms(3);
    chk({31'h0, demandPos != snap && demandPos - snap <= 32'h0000_0028}, 32'h0000_0001);
    obj(ipcp_pkg::OBJ_CTRL, 32'h0000_0000);
    sb(12, 1'b0);
    chk({31'h0, interpolationRunning}, 32'h0000_0000);
    obj(ipcp_pkg::OBJ_CTRL, 32'h0000_0010);
    obj(ipcp_pkg::OBJ_TIME_IDX, 32'h0000_0000);
    sb(12, 1'b0);
    $display("test speed limit and index done");
    finalReport();
  end
endmodule
